//--- realtime_dma.sv
// Real-time DMA engine: AHB-Lite registers, arbiter, transfer engine, protection
//
// Overview of operation
// - Ten software-configured channels move data between peripherals and memory.
// - Each channel pulses its own interrupt at transfer start and/or end.
// - Four priority levels per channel; one selected channel may override all.
// - Element width per channel is 8, 16, 32 or 64 bits.
// - Separate read and write ports; one word per cycle when not stalled.
// - Burst is flagged only for accesses inside the external memory port window.
// - Trigger comes from a system source or another channel's completion.
// - Triggers are edge sensitive; a held level starts only one transfer.
// - Linear or circular addressing; one-shot or continuous; interrupt options.
// - Protection unit checks every access against windows from the safety_security_firewall.
// - Each channel belongs to a security zone that selects its window.
// - In lockstep mode a duplicate arbiter is compared to detect faults.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "realtime_dma_consts.svh"
module realtime_dma
	import realtime_dma_pkg::*;
#(
	parameter int          NCH        = 10,
	parameter int          NTRIG      = 16,
	parameter int          DW         = 64,
	parameter int          FIFO_DEPTH = 16,
	parameter logic [31:0] EXT_BASE   = 32'h80000000,
	parameter logic [31:0] EXT_LIMIT  = 32'hbfffffff
) (
	// Clock, reset, enable
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 ce,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Triggers and interrupts
	input  wire logic [NTRIG-1:0]     trig_in,
	output logic [NCH-1:0]            chan_irq,
	// Read port
	output logic                      rd_req,
	output bus_req_t                  rd_cmd,
	input  wire logic                 rd_ack,
	input  wire logic [DW-1:0]        rd_data,
	// Write port
	output logic                      wr_req,
	output bus_req_t                  wr_cmd,
	output logic [DW-1:0]             wr_data,
	input  wire logic                 wr_ack,
	// Protection and lockstep
	input  wire zone_win_t [3:0]      zone_win,
	input  wire logic                 lockstep_en,
	output logic                      lockstep_err
);
	localparam int NSRC = NTRIG + NCH;

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [4:0] chan_of(input logic [11:0] a);
		logic ok;
		ok = !a[`GLB_BIT] && (a[8:`CH_STRIDE_LSB] < 4'(NCH));
		return {ok, a[8:`CH_STRIDE_LSB]};
	endfunction

	// Elevated channel first, then level 3 down to 0, round robin after last grant
	function automatic logic [4:0] pick(input logic [NCH-1:0] pend,
		input chan_ctrl_t ctl [NCH], input logic [4:0] hi, input logic [3:0] last);
		logic [4:0] res;
		int         c;
		res = 5'h00;
		if (hi[4] && (hi[3:0] < 4'(NCH)) && pend[hi[3:0]])
			res = {1'b1, hi[3:0]};
		for (int lv = 0; lv < `NUM_LEVELS; lv++)
			for (int k = 0; k < NCH; k++)
			begin
				c = (int'(last) + 1 + k) % NCH;
				if (!res[4] && pend[c] && (ctl[c].prio == 2'(`NUM_LEVELS - 1 - lv)))
					res = {1'b1, 4'(c)};
			end
		return res;
	endfunction

	function automatic walk_t step(input walk_t w, input logic [15:0] wrap,
		input logic circ, input logic [1:0] width);
		walk_t n;
		n.idx = w.idx + 16'h1;
		n.off = w.off + (32'h1 << width);
		if (circ && (n.idx == wrap))
			n = '0;
		return n;
	endfunction

	function automatic logic zone_ok(input logic [31:0] a, input logic [1:0] z);
		return (a >= zone_win[z].base) && (a <= zone_win[z].limit);
	endfunction

	function automatic logic in_ext(input logic [31:0] a);
		return (a >= EXT_BASE) && (a <= EXT_LIMIT);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [31:0]     src_reg [NCH];
	logic [31:0]     dst_reg [NCH];
	logic [31:0]     cnt_reg [NCH];
	chan_ctrl_t      ctrl_reg [NCH];
	logic [4:0]      hipri_reg;
	logic [NCH-1:0]  pend_reg;
	logic [NCH-1:0]  chfault_reg;
	logic [NCH-1:0]  done_pulse_reg;
	logic [NCH-1:0]  irq_reg;
	logic [NSRC-1:0] src_prev_reg;
	logic            ap_wr_reg;
	logic [11:0]     ap_addr_reg;
	logic [31:0]     hrdata_reg;
	logic [31:0]     rdata_next;
	eng_state_t      state_reg;
	logic [3:0]      act_reg;
	logic [3:0]      rr_reg;
	logic [3:0]      rr_shadow_reg;
	logic [4:0]      gnt_main_reg;
	logic [4:0]      gnt_shadow_reg;
	logic            lock_err_reg;
	logic            run_fault_reg;
	logic [15:0]     rd_left_reg;
	logic [15:0]     wr_left_reg;
	walk_t           rd_walk_reg;
	walk_t           wr_walk_reg;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait, always OKAY, read data registered in address phase

	logic       take;
	logic [4:0] wsel;
	logic [4:0] rsel;
	assign take      = hsel & hready & htrans[1];
	assign wsel      = chan_of(ap_addr_reg);
	assign rsel      = chan_of(haddr[11:0]);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_reg   <= 1'b0;
			ap_addr_reg <= 12'h000;
		end
		else if (ce)
		begin
			ap_wr_reg   <= take & hwrite;
			ap_addr_reg <= haddr[11:0];
		end
	end

	always_comb
	begin
		rdata_next = `WORD_RST;
		if (rsel[4])
			unique case (haddr[4:2])
				`OFF_SRC:  rdata_next = src_reg[rsel[3:0]];
				`OFF_DST:  rdata_next = dst_reg[rsel[3:0]];
				`OFF_CNT:  rdata_next = cnt_reg[rsel[3:0]];
				`OFF_CTRL: rdata_next = 32'(ctrl_reg[rsel[3:0]]);
				`OFF_STAT: rdata_next = {13'h0000, chfault_reg[rsel[3:0]], pend_reg[rsel[3:0]],
					(state_reg != ST_IDLE) && (act_reg == rsel[3:0]),
					(act_reg == rsel[3:0]) ? wr_left_reg : 16'h0000};
				default:   rdata_next = `WORD_RST;
			endcase
		else if (haddr[`GLB_BIT])
			unique case (haddr[4:2])
				`OFF_HIPRI:  rdata_next = 32'(hipri_reg);
				`OFF_STATUS: rdata_next = {state_reg != ST_IDLE, 27'(act_reg), 4'h0} | 32'(pend_reg);
				`OFF_FAULT:  rdata_next = {lock_err_reg, 31'(chfault_reg)};
				default:     rdata_next = `WORD_RST;
			endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= `WORD_RST;
		else if (ce && take && !hwrite)
			hrdata_reg <= rdata_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel configuration; enable drops after a one-shot or faulted transfer

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hipri_reg <= `HIPRI_RST;
			for (int c = 0; c < NCH; c++)
			begin
				src_reg[c]  <= `WORD_RST;
				dst_reg[c]  <= `WORD_RST;
				cnt_reg[c]  <= `WORD_RST;
				ctrl_reg[c] <= `CTRL_RST;
			end
		end
		else if (ce)
		begin
			if (state_reg == ST_DONE && (!ctrl_reg[act_reg].continuous || run_fault_reg))
				ctrl_reg[act_reg].en <= 1'b0;
			if (ap_wr_reg && wsel[4])
				unique case (ap_addr_reg[4:2])
					`OFF_SRC:  src_reg[wsel[3:0]]  <= hwdata;
					`OFF_DST:  dst_reg[wsel[3:0]]  <= hwdata;
					`OFF_CNT:  cnt_reg[wsel[3:0]]  <= hwdata;
					`OFF_CTRL: ctrl_reg[wsel[3:0]] <= hwdata[16:0];
					default:   ;
				endcase
			else if (ap_wr_reg && ap_addr_reg[`GLB_BIT] && ap_addr_reg[4:2] == `OFF_HIPRI)
				hipri_reg <= hwdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Triggers: system sources then channel completions, rising edge only

	logic [NSRC-1:0] src_vec;
	logic [NSRC-1:0] src_edge;
	logic [NCH-1:0]  pend_set;
	logic [4:0]      gnt;
	logic [4:0]      gnt_shadow;
	logic            start;
	assign src_vec    = {done_pulse_reg, trig_in};
	assign src_edge   = src_vec & ~src_prev_reg;
	assign gnt        = pick(pend_reg, ctrl_reg, hipri_reg, rr_reg);
	assign gnt_shadow = pick(pend_reg, ctrl_reg, hipri_reg, rr_shadow_reg);
	assign start      = (state_reg == ST_IDLE) && gnt[4];

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
			pend_set[c] = ctrl_reg[c].en && (int'(ctrl_reg[c].trig_sel) < NSRC)
				&& src_edge[ctrl_reg[c].trig_sel];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			src_prev_reg <= '0;
			pend_reg     <= '0;
		end
		else if (ce)
		begin
			src_prev_reg <= src_vec;
			for (int c = 0; c < NCH; c++)
				if (pend_set[c])
					pend_reg[c] <= 1'b1;
				else if (!ctrl_reg[c].en || (start && gnt[3:0] == 4'(c)))
					pend_reg[c] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer engine; one channel active, read and write sides run independently

	chan_ctrl_t act_ctl;
	logic [31:0] rd_addr;
	logic [31:0] wr_addr;
	logic        rd_ok;
	logic        wr_ok;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        rd_fire;
	logic        wr_fire;
	logic        fault_now;
	assign act_ctl   = ctrl_reg[act_reg];
	assign rd_addr   = src_reg[act_reg] + rd_walk_reg.off;
	assign wr_addr   = dst_reg[act_reg] + wr_walk_reg.off;
	assign rd_ok     = zone_ok(rd_addr, act_ctl.zone);
	assign wr_ok     = zone_ok(wr_addr, act_ctl.zone);
	assign rd_req    = (state_reg == ST_RUN) && (rd_left_reg != 16'h0) && fifo_in_ready && rd_ok;
	assign wr_req    = (state_reg == ST_RUN) && fifo_out_valid && wr_ok;
	assign rd_fire   = rd_req & rd_ack;
	assign wr_fire   = wr_req & wr_ack;
	assign fault_now = ((rd_left_reg != 16'h0) && !rd_ok) || (fifo_out_valid && !wr_ok);
	assign rd_cmd    = '{addr: rd_addr, size: act_ctl.width,
		burst: act_ctl.burst && in_ext(rd_addr)};
	assign wr_cmd    = '{addr: wr_addr, size: act_ctl.width,
		burst: act_ctl.burst && in_ext(wr_addr)};

	dma_fifo #(
		.W     (DW),
		.DEPTH (FIFO_DEPTH)
	) data_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.flush     (state_reg == ST_DONE),
		.in_valid  (rd_fire),
		.in_ready  (fifo_in_ready),
		.in_data   (rd_data),
		.out_valid (fifo_out_valid),
		.out_ready (wr_fire),
		.out_data  (wr_data)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg     <= ST_IDLE;
			act_reg       <= 4'h0;
			rr_reg        <= 4'h0;
			rd_left_reg   <= 16'h0000;
			wr_left_reg   <= 16'h0000;
			rd_walk_reg   <= '0;
			wr_walk_reg   <= '0;
			run_fault_reg <= 1'b0;
		end
		else if (ce)
		begin
			unique case (state_reg)
				ST_IDLE:
					if (start)
					begin
						act_reg       <= gnt[3:0];
						rr_reg        <= gnt[3:0];
						rd_left_reg   <= cnt_reg[gnt[3:0]][`CNT_LEN_MSB:0];
						wr_left_reg   <= cnt_reg[gnt[3:0]][`CNT_LEN_MSB:0];
						rd_walk_reg   <= '0;
						wr_walk_reg   <= '0;
						run_fault_reg <= 1'b0;
						state_reg     <= ST_RUN;
					end
				ST_RUN:
				begin
					if (rd_fire)
					begin
						rd_left_reg <= rd_left_reg - 16'h1;
						rd_walk_reg <= step(rd_walk_reg, cnt_reg[act_reg][31:`CNT_WRAP_LSB],
							act_ctl.circular, act_ctl.width);
					end
					if (wr_fire)
					begin
						wr_left_reg <= wr_left_reg - 16'h1;
						wr_walk_reg <= step(wr_walk_reg, cnt_reg[act_reg][31:`CNT_WRAP_LSB],
							act_ctl.circular, act_ctl.width);
					end
					if (fault_now)
					begin
						run_fault_reg <= 1'b1;
						state_reg     <= ST_DONE;
					end
					else if (wr_left_reg == 16'h0)
						state_reg <= ST_DONE;
				end
				ST_DONE:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pulses, completion links and per-channel fault flags

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_reg        <= '0;
			done_pulse_reg <= '0;
			chfault_reg    <= '0;
		end
		else if (ce)
		begin
			irq_reg        <= '0;
			done_pulse_reg <= '0;
			if (start && ctrl_reg[gnt[3:0]].int_start)
				irq_reg[gnt[3:0]] <= 1'b1;
			if (state_reg == ST_DONE && act_ctl.int_end)
				irq_reg[act_reg] <= 1'b1;
			if (state_reg == ST_DONE && !run_fault_reg)
				done_pulse_reg[act_reg] <= 1'b1;
			for (int c = 0; c < NCH; c++)
				if (state_reg == ST_DONE && run_fault_reg && act_reg == 4'(c))
					chfault_reg[c] <= 1'b1;
				else if (ap_wr_reg && ap_addr_reg[`GLB_BIT] && ap_addr_reg[4:2] == `OFF_FAULT
					&& hwdata[c])
					chfault_reg[c] <= 1'b0;
		end
	end
	assign chan_irq = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Lockstep: a second arbiter with its own history must agree with the first

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rr_shadow_reg  <= 4'h0;
			gnt_main_reg   <= 5'h00;
			gnt_shadow_reg <= 5'h00;
			lock_err_reg   <= 1'b0;
		end
		else if (ce)
		begin
			if (state_reg == ST_IDLE && gnt_shadow[4])
				rr_shadow_reg <= gnt_shadow[3:0];
			gnt_main_reg   <= gnt;
			gnt_shadow_reg <= gnt_shadow;
			if (lockstep_en && gnt_main_reg != gnt_shadow_reg)
				lock_err_reg <= 1'b1;
			else if (ap_wr_reg && ap_addr_reg[`GLB_BIT] && ap_addr_reg[4:2] == `OFF_FAULT
				&& hwdata[31])
				lock_err_reg <= 1'b0;
		end
	end
	assign lockstep_err = lock_err_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_start_ok;
		ce && start && (gnt[3:0] == 4'h0) && ctrl_reg[0].int_start;
	endsequence

	AST_RUN_ONLY: assert property (rd_req || wr_req |-> state_reg == ST_RUN)
		else $error("port request outside a transfer");
	AST_IRQ_START: assert property (s_start_ok |=> chan_irq[0])
		else $error("start interrupt missing");
	AST_HI_FIRST: assert property (hipri_reg[4] && hipri_reg[3:0] < 4'(NCH)
		&& pend_reg[hipri_reg[3:0]] |-> gnt == {1'b1, hipri_reg[3:0]})
		else $error("elevated channel not granted");
	AST_SIZE: assert property (rd_req |-> rd_cmd.size == ctrl_reg[act_reg].width)
		else $error("read size differs from channel width");
	AST_BACKPRESS: assert property (!fifo_in_ready |-> !rd_req)
		else $error("read issued while FIFO full");
	AST_BURST: assert property (rd_req && rd_cmd.burst |-> in_ext(rd_cmd.addr))
		else $error("burst outside external memory window");
	AST_EDGE: assert property ($rose(pend_reg[0]) |-> $past(src_edge[ctrl_reg[0].trig_sel]))
		else $error("pending set without trigger edge");
	AST_ONESHOT: assert property (ce && state_reg == ST_DONE && !act_ctl.continuous
		|=> !ctrl_reg[$past(act_reg)].en && state_reg == ST_IDLE)
		else $error("one-shot channel still enabled");
	AST_MPU: assert property (wr_req |-> zone_ok(wr_cmd.addr, act_ctl.zone))
		else $error("write outside zone window");
endmodule // realtime_dma

//--- realtime_dma_consts.svh
// Register offsets, field positions and reset values of the real-time DMA engine
`ifndef REALTIME_DMA_CONSTS_SVH
`define REALTIME_DMA_CONSTS_SVH

// Channel registers: byte offset = channel * 0x20 + index * 4
`define CH_STRIDE_LSB   5
`define OFF_SRC         3'h0
`define OFF_DST         3'h1
`define OFF_CNT         3'h2
`define OFF_CTRL        3'h3
`define OFF_STAT        3'h4
// Global registers sit above the channel block (byte address bit 9 set)
`define GLB_BIT         9
`define OFF_HIPRI       3'h0
`define OFF_STATUS      3'h1
`define OFF_FAULT       3'h2
// Count register fields
`define CNT_LEN_MSB     15
`define CNT_WRAP_LSB    16
// Reset values
`define CTRL_RST        17'h00000
`define HIPRI_RST       5'h00
`define WORD_RST        32'h00000000
// Number of priority levels and security zones
`define NUM_LEVELS      4
`define NUM_ZONES       4

`endif

//--- realtime_dma_pkg.sv
// Types shared by the real-time DMA engine, its memory model and its bench
package realtime_dma_pkg;

	typedef struct packed {
		logic       burst;
		logic [1:0] zone;
		logic       int_end;
		logic       int_start;
		logic       circular;
		logic       continuous;
		logic [4:0] trig_sel;
		logic [1:0] prio;
		logic [1:0] width;
		logic       en;
	} chan_ctrl_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0]  size;
		logic        burst;
	} bus_req_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
	} zone_win_t;

	typedef struct packed {
		logic [15:0] idx;
		logic [31:0] off;
	} walk_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} eng_state_t;

endpackage

//--- dma_fifo.sv
// Parameterised synchronous FIFO between the read and write ports
`timescale 1ns/1ps
module dma_fifo #(
	parameter int W     = 64,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	input  wire logic         flush,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic [PW:0]   count_reg;
	logic          push;
	logic          pop;

	assign in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rptr_reg];

	always_ff @(posedge hclk)
	begin
		if (ce && push)
			mem[wptr_reg] <= in_data;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wptr_reg  <= '0;
			rptr_reg  <= '0;
			count_reg <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wptr_reg  <= '0;
				rptr_reg  <= '0;
				count_reg <= '0;
			end
			else
			begin
				if (push)
					wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
				if (pop)
					rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
				count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
			end
		end
	end
endmodule // dma_fifo

//--- dma_mem_model.sv
// Memory and peripheral responder on the engine's read and write ports
`timescale 1ns/1ps
module dma_mem_model
	import realtime_dma_pkg::*;
(
	// Clock, reset, answer delay
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [1:0]  lag,
	// Read port
	input  wire logic        rd_req,
	input  wire bus_req_t    rd_cmd,
	output logic             rd_ack,
	output logic [63:0]      rd_data,
	// Write port
	input  wire logic        wr_req,
	input  wire bus_req_t    wr_cmd,
	input  wire logic [63:0] wr_data,
	output logic             wr_ack
);
	logic [1:0]  rd_wait_reg;
	logic [1:0]  wr_wait_reg;
	logic [31:0] wadr [16];
	logic [63:0] wdat [16];
	int          wn;
	int          bok;
	int          bbad;

	////////////////////////////////////////////////////////////////////////////////
	// Each port answers on its own, after lag cycles
	assign rd_ack = rd_req && (rd_wait_reg >= lag);
	assign wr_ack = wr_req && (wr_wait_reg >= lag);
	// Outside an accepted read the lines show the inverse, so a stale capture shows up
	assign rd_data = rd_ack ? {rd_cmd.addr ^ 32'h5a5a5a5a, rd_cmd.addr}
		: ~{rd_cmd.addr ^ 32'h5a5a5a5a, rd_cmd.addr};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_wait_reg <= 2'h0;
			wr_wait_reg <= 2'h0;
		end
		else
		begin
			rd_wait_reg <= (rd_req && !rd_ack) ? rd_wait_reg + 2'h1 : 2'h0;
			wr_wait_reg <= (wr_req && !wr_ack) ? wr_wait_reg + 2'h1 : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic ext(input logic [31:0] a);
		return a >= 32'h80000000 && a <= 32'hbfffffff;
	endfunction

	// Log accepted writes; judge every burst mark against the external window
	always @(posedge hclk)
	begin
		if (wr_ack === 1'b1)
		begin
			wadr[wn % 16] = wr_cmd.addr;
			wdat[wn % 16] = wr_data;
			wn = wn + 1;
		end
		if (rd_ack === 1'b1 && rd_cmd.burst === 1'b1)
			if (ext(rd_cmd.addr)) bok = bok + 1; else bbad = bbad + 1;
		if (wr_ack === 1'b1 && wr_cmd.burst === 1'b1)
			if (ext(wr_cmd.addr)) bok = bok + 1; else bbad = bbad + 1;
	end
endmodule // dma_mem_model

//--- realtime_dma_engine_bench.sv
// Self-checking bench for the real-time DMA engine
`timescale 1ns/1ps
module realtime_dma_engine_bench
	import realtime_dma_pkg::*;
;
	logic            hclk;
	logic            hresetn;
	logic            hsel;
	logic [31:0]     haddr;
	logic [1:0]      htrans;
	logic            hwrite;
	logic [31:0]     hwdata;
	logic [31:0]     hrdata;
	logic            hreadyout;
	logic            hresp;
	logic [15:0]     trig_in;
	logic [9:0]      chan_irq;
	logic            rd_req;
	bus_req_t        rd_cmd;
	logic            rd_ack;
	logic [63:0]     rd_data;
	logic            wr_req;
	bus_req_t        wr_cmd;
	logic [63:0]     wr_data;
	logic            wr_ack;
	zone_win_t [3:0] zone_win;
	logic            lockstep_err;
	logic [1:0]      lag;
	logic [31:0]     q;
	int              err_total;
	int              cmp_count;
	int              cycles;
	int              took;
	int              irq_n [10];

	realtime_dma u_dut (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trig_in(trig_in), .chan_irq(chan_irq),
		.rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ack(rd_ack), .rd_data(rd_data),
		.wr_req(wr_req), .wr_cmd(wr_cmd), .wr_data(wr_data), .wr_ack(wr_ack),
		.zone_win(zone_win), .lockstep_en(1'b1), .lockstep_err(lockstep_err)
	);

	dma_mem_model u_mem (
		.hclk(hclk), .hresetn(hresetn), .lag(lag),
		.rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ack(rd_ack), .rd_data(rd_data),
		.wr_req(wr_req), .wr_cmd(wr_cmd), .wr_data(wr_data), .wr_ack(wr_ack)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Interrupt pulses last one cycle, so each high sample is one event
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		for (int i = 0; i < 10; i++)
			if (chan_irq[i] === 1'b1) irq_n[i] = irq_n[i] + 1;
		if (cycles == 20000)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED at %0t: run hung", $time);
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Single word transfer; entered just after a rising edge
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string what);
		ahb(1'b0, a, 32'h0);
		chk({32'h0, q}, {32'h0, e}, what);
	endtask

	task automatic setup(input int c, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] n, input logic [31:0] ctl);
		ahb(1'b1, 32'(c * 32), s);
		ahb(1'b1, 32'(c * 32 + 4), d);
		ahb(1'b1, 32'(c * 32 + 8), n);
		ahb(1'b1, 32'(c * 32 + 12), ctl);
	endtask

	// Enabled, 64-bit, both interrupts, lowest priority, one-shot, linear
	function automatic logic [31:0] ctl(input logic [4:0] t, input logic [1:0] z,
		input logic b);
		return {15'h0, b, z, 2'h3, 2'h0, t, 2'h0, 2'h3, 1'b1};
	endfunction

	task automatic fire(input int t, input int n);
		trig_in[t] <= 1'b1;
		took = 0;
		while (u_mem.wn < n && took < 300)
		begin
			@(posedge hclk);
			took++;
		end
	endtask

	function automatic logic [63:0] pat(input logic [31:0] a);
		return {a ^ 32'h5a5a5a5a, a};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		trig_in = 16'h0;
		lag = 2'h0;
		err_total = 0;
		cmp_count = 0;
		cycles = 0;
		irq_n = '{default: 0};
		zone_win = {{32'h0, 32'hffffffff}, {32'h0, 32'hffffffff},
			{32'h0, 32'h00000fff}, {32'h0, 32'hffffffff}};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(32'h00c, 32'h0, "ctrl0 reset");
		rd(32'h12c, 32'h0, "ctrl9 reset");
		rd(32'h200, 32'h0, "hipri reset");
		rd(32'h208, 32'h0, "fault reset");
		chk({63'h0, hresp}, 64'h0, "okay response");
		$display("test reset_values done");
		// Widths, levels and sources in every channel, all disabled
		for (int i = 0; i < 10; i++)
			ahb(1'b1, 32'(i * 32 + 12), 32'((i % 4) * 2 + (3 - i % 4) * 8 + i * 32));
		for (int i = 0; i < 10; i++)
			rd(32'(i * 32 + 12), 32'((i % 4) * 2 + (3 - i % 4) * 8 + i * 32), "ctrl");
		ahb(1'b1, 32'h200, 32'h13);
		rd(32'h200, 32'h13, "elevated channel");
		ahb(1'b1, 32'h14c, 32'h1);
		rd(32'h14c, 32'h0, "no eleventh channel");
		$display("test config done");
		setup(0, 32'h1000, 32'h2000, 32'h3, ctl(5'h0, 2'h0, 1'b0));
		fire(0, 3);
		chk(64'(took <= 10), 64'h1, "word rate");
		repeat (20) @(posedge hclk);
		chk(64'(u_mem.wn), 64'h3, "held trigger");
		chk(64'(irq_n[0]), 64'h2, "start and end irq");
		for (int k = 0; k < 3; k++)
		begin
			chk(u_mem.wdat[k], pat(32'(32'h1000 + k * 8)), "data");
			chk({32'h0, u_mem.wadr[k]}, 64'(32'h2000 + k * 8), "linear dst");
		end
		trig_in[0] <= 1'b0;
		$display("test transfer done");
		// Slow partner while channel 1 follows channel 0
		lag <= 2'h2;
		setup(0, 32'h1000, 32'h2000, 32'h3, ctl(5'h0, 2'h0, 1'b0));
		setup(1, 32'h3000, 32'h4000, 32'h1, ctl(5'h10, 2'h0, 1'b0));
		fire(0, 7);
		chk(64'(u_mem.wn), 64'h7, "linked count");
		chk(u_mem.wdat[6], pat(32'h3000), "linked data");
		chk({32'h0, u_mem.wadr[6]}, 64'h4000, "linked dst");
		trig_in[0] <= 1'b0;
		lag <= 2'h0;
		$display("test linking done");
		setup(2, 32'h5000, 32'h80000000, 32'h2, ctl(5'h2, 2'h0, 1'b1));
		fire(2, 9);
		chk(64'(u_mem.bok), 64'h2, "burst inside window");
		chk(64'(u_mem.bbad), 64'h0, "burst outside window");
		trig_in[2] <= 1'b0;
		$display("test burst done");
		// Zone 1 window excludes both addresses
		setup(3, 32'h6000, 32'h7000, 32'h2, ctl(5'h3, 2'h1, 1'b0));
		trig_in[3] <= 1'b1;
		repeat (30) @(posedge hclk);
		chk(64'(u_mem.wn), 64'h9, "blocked writes");
		rd(32'h208, 32'h8, "fault flag");
		rd(32'h06c, ctl(5'h3, 2'h1, 1'b0) & 32'hfffffffe, "aborted ctrl");
		chk(64'(irq_n[3]), 64'h2, "abort irq");
		ahb(1'b1, 32'h208, 32'h8);
		rd(32'h208, 32'h0, "fault cleared");
		chk({63'h0, lockstep_err}, 64'h0, "lockstep quiet");
		$display("test protection done");
		// Wrap after two elements; continuous keeps the channel enabled
		setup(4, 32'h8000, 32'h9000, 32'h00020003, ctl(5'h4, 2'h0, 1'b0) | 32'hc00);
		fire(4, 12);
		chk({32'h0, u_mem.wadr[11]}, 64'h9000, "circular dst");
		chk(u_mem.wdat[10], pat(32'h8008), "circular src");
		rd(32'h08c, ctl(5'h4, 2'h0, 1'b0) | 32'hc00, "continuous ctrl");
		trig_in[4] <= 1'b0;
		$display("test circular done");
		wrap_up();
	end
endmodule // realtime_dma_engine_bench
